/* File: verilog/frc_top.sv */
// Serial flash command block for reset, unique ID read and parameter table read.
`timescale 1ns/10ps
`default_nettype none
module frc_top
#(
  parameter logic [7:0] MAKER_ID = 8'h5C // Arbitrary maker code.
)
(
  input  wire logic                   clk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   sclk_i,
  input  wire frc_pkg::frc_link_in_t  link_i,
  output var  frc_pkg::frc_link_out_t link_o,
  input  wire logic [127:0]           unique_id_i,
  input  wire logic                   prog_busy_i,
  output var  logic                   soft_reset_o,
  output var  logic                   abort_prog_o,
  output var  logic                   reset_busy_o,
  output var  logic                   armed_o
);
  import frc_pkg::*;

  // Maps a complete opcode onto the transfer it starts.
  function automatic frc_mode_t decode_mode(input logic [7:0] op);
    frc_mode_t m;
    m = MODE_OTHER;
    if (op == OP_UNIQUE_ID)
      m = MODE_UID;
    else if (op == OP_PARAM_TABLE)
      m = MODE_TABLE;
    return m;
  endfunction

  // True when a frame of exactly eight bits carried the wanted opcode.
  function automatic logic short_cmd(input logic eight, input logic [7:0] op,
                                     input logic [7:0] want);
    return eight && (op == want);
  endfunction

  // Next table address while streaming bytes.
  function automatic logic [23:0] addr_step(input logic [23:0] a);
    return a + 24'h000001;
  endfunction

  // Link side, clocked by the serial clock; chip select high clears all but the frame summary and ROM data.
  logic [CNT_W-1:0] bit_cnt;
  logic [6:0]       op_shift;
  frc_mode_t        mode;
  logic [23:0]      table_addr;
  logic [7:0]       rom_data;
  logic [7:0]       out_byte;
  logic [2:0]       byte_idx;
  logic [6:0]       uid_idx;
  logic             data_on;
  logic             tx_bit;
  logic             table_start;
  logic             uid_start;
  logic             table_next;
  logic [7:0]       frame_op   = 8'h00;
  logic             frame_eight = 1'b0;
  logic             frame_tog  = 1'b0;

  // Strobes that start a stream after the dummy bits and fetch each further table byte.
  assign table_start = !data_on && mode == MODE_TABLE && bit_cnt == CNT_PT_LAST;
  assign uid_start   = !data_on && mode == MODE_UID && bit_cnt == CNT_UID_LAST;
  assign table_next  = data_on && mode == MODE_TABLE && byte_idx == 3'h0;

  // Counts the bits of a frame and stops at the first data bit.
  always_ff @(posedge sclk_i or posedge link_i.cs_n)
  begin
    if (link_i.cs_n)
      bit_cnt <= '0;
    else if (bit_cnt != CNT_DATA)
      bit_cnt <= bit_cnt + CNT_W'(1);
  end

  // The opcode is taken from the serial input line alone.
  always_ff @(posedge sclk_i or posedge link_i.cs_n)
  begin
    if (link_i.cs_n)
    begin
      op_shift <= 7'h00;
      mode     <= MODE_IDLE;
    end
    else if (bit_cnt < CNT_OPCODE_LAST)
      op_shift <= {op_shift[5:0], link_i.si};
    else if (bit_cnt == CNT_OPCODE_LAST)
      mode <= decode_mode({op_shift, link_i.si});
  end

  // Frame summary survives chip select so the system side can judge the frame.
  always_ff @(posedge sclk_i)
  begin
    if (!link_i.cs_n)
    begin
      if (bit_cnt == '0)
      begin
        frame_tog   <= ~frame_tog;
        frame_eight <= 1'b0;
      end
      else if (bit_cnt == CNT_OPCODE_LAST)
      begin
        frame_op    <= {op_shift, link_i.si};
        frame_eight <= 1'b1;
      end
      else if (bit_cnt == CNT_ADDR_FIRST)
        frame_eight <= 1'b0;
    end
  end

  // Shifts in the table address and steps it once for each byte sent.
  always_ff @(posedge sclk_i or posedge link_i.cs_n)
  begin
    if (link_i.cs_n)
      table_addr <= 24'h000000;
    else if (mode == MODE_TABLE && bit_cnt >= CNT_ADDR_FIRST && bit_cnt <= CNT_ADDR_LAST)
      table_addr <= {table_addr[22:0], link_i.si};
    else if (table_next)
      table_addr <= addr_step(table_addr);
    else if (table_start)
      table_addr <= addr_step(table_addr);
  end

  frc_table_rom #(
    .MAKER_ID (MAKER_ID)
  ) u_rom (
    .clk_i  (sclk_i),
    .addr_i (table_addr),
    .data_o (rom_data)
  );

  // Output sequencing: a byte stream for the table, a bit stream for the identifier.
  always_ff @(posedge sclk_i or posedge link_i.cs_n)
  begin
    if (link_i.cs_n)
    begin
      data_on  <= 1'b0;
      out_byte <= 8'h00;
      byte_idx <= 3'h0;
      uid_idx  <= 7'h00;
    end
    else if (!data_on)
    begin
      if (table_start)
      begin
        data_on  <= 1'b1;
        out_byte <= rom_data;
        byte_idx <= 3'h7;
      end
      else if (uid_start)
      begin
        data_on <= 1'b1;
        uid_idx <= 7'h7F;
      end
    end
    else if (mode == MODE_TABLE)
    begin
      byte_idx <= byte_idx - 3'h1;
      if (table_next)
        out_byte <= rom_data;
    end
    else
      uid_idx <= uid_idx - 7'h01;
  end

  // The identifier is only ever read, never written.
  always_comb
  begin
    if (mode == MODE_UID)
      tx_bit = unique_id_i[uid_idx];
    else
      tx_bit = out_byte[byte_idx];
  end

  // Registers the serial output on the falling edge; chip select high silences it at once.
  always_ff @(negedge sclk_i or posedge link_i.cs_n)
  begin
    if (link_i.cs_n)
    begin
      link_o.so      <= 1'b0;
      link_o.so_oe_n <= 1'b1;
    end
    else
    begin
      link_o.so      <= data_on ? tx_bit : 1'b0;
      link_o.so_oe_n <= ~data_on;
    end
  end

  // System side: chip select and the frame toggle cross through three stages.
  logic [2:0]            cs_sync;
  logic [2:0]            tog_sync;
  logic                  cs_state;
  logic                  tog_state;
  logic                  seen_tog;
  logic [1:0]            prime_cnt;
  logic                  cs_rise;
  logic                  frame_new;
  frc_ctl_t              ctl;
  logic [RECOVERY_W-1:0] recover_cnt;

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      cs_sync  <= 3'h7;
      tog_sync <= 3'h0;
    end
    else
    begin
      cs_sync  <= {cs_sync[1:0], link_i.cs_n};
      tog_sync <= {tog_sync[1:0], frame_tog};
    end
  end

  // A synchronised level is taken only once the second and third stages agree.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      cs_state  <= 1'b1;
      tog_state <= 1'b0;
    end
    else
    begin
      if (cs_sync[1] == cs_sync[2])
        cs_state <= cs_sync[2];
      if (tog_sync[1] == tog_sync[2])
        tog_state <= tog_sync[2];
    end
  end

  // A chip select rise ends a frame; only a frame with a fresh toggle counts.
  assign cs_rise   = cs_sync[1] && cs_sync[2] && !cs_state;
  assign frame_new = cs_rise && (tog_state != seen_tog) && (prime_cnt == 2'(PRIME_CYCLES));

  // After reset the last frame seen is taken as already handled.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      seen_tog  <= 1'b0;
      prime_cnt <= 2'h0;
    end
    else if (prime_cnt != 2'(PRIME_CYCLES))
    begin
      seen_tog  <= tog_state;
      prime_cnt <= prime_cnt + 2'h1;
    end
    else if (cs_rise)
      seen_tog <= tog_state;
  end

  // Judges each frame finished outside recovery: arm, execute, or cancel a pending reset.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      ctl          <= CTL_IDLE;
      recover_cnt  <= '0;
      soft_reset_o <= 1'b0;
      abort_prog_o <= 1'b0;
    end
    else
    begin
      soft_reset_o <= 1'b0;
      abort_prog_o <= 1'b0;
      case (ctl)
        CTL_IDLE, CTL_ARMED:
        begin
          if (frame_new)
          begin
            if (short_cmd(frame_eight, frame_op, OP_RESET_ARM))
              ctl <= CTL_ARMED;
            else if (short_cmd(frame_eight, frame_op, OP_RESET_EXEC) && ctl == CTL_ARMED)
            begin
              ctl          <= CTL_RECOVER;
              soft_reset_o <= 1'b1;
              abort_prog_o <= prog_busy_i;
              recover_cnt  <= RECOVERY_W'(RECOVERY_CYCLES - 1);
            end
            else
              ctl <= CTL_IDLE;
          end
        end
        CTL_RECOVER:
        begin
          if (recover_cnt == '0)
            ctl <= CTL_IDLE;
          else
            recover_cnt <= recover_cnt - RECOVERY_W'(1);
        end
        default:
          ctl <= CTL_IDLE;
      endcase
    end
  end

  // Status levels decoded straight from the control state.
  assign reset_busy_o = (ctl == CTL_RECOVER);
  assign armed_o      = (ctl == CTL_ARMED);

endmodule
`default_nettype wire

/* File: verilog/frc_pkg.sv */
// Shared constants and types for the flash reset, unique ID and parameter table commands.
// How it works
// - No-operation only cancels an armed reset and touches nothing else.
// - Only the serial input line is sampled; upper I/O lines are never looked at.
// - A valid reset-execute returns to standby and restores all volatile defaults.
// - Reset happens only when reset-arm is the very previous command.
// - A reset during program or erase aborts that operation.
// - The 128-bit unique identifier is read only, with no write path.
// - Opcode 4B selects the unique-ID read.
// - Unique-ID read: opcode, four dummy bytes, then 128 identifier bits.
// - Table read: opcode 5A, three address bytes, one dummy byte, then data.
// - Raising chip select stops data output at once.
// - Bytes 00 to 03 read 53, 46, 44, 50.
// - Byte 04 reads 00 and byte 05 reads 01.
// - Byte 06 reads 01, announcing two headers.
// - Bytes 07, 0F and 17 always read FF.
// - First header: 00, 00, 01, 09 at bytes 08 to 0B.
// - First header pointer bytes 0C to 0E read 30, 00, 00.
// - Second header: maker code, 00, 01, 03, then pointer 60, 00, 00.
package frc_pkg;

  localparam logic [7:0] OP_NO_OPERATION = 8'h00;
  localparam logic [7:0] OP_RESET_ARM    = 8'h66;
  localparam logic [7:0] OP_RESET_EXEC   = 8'h99;
  localparam logic [7:0] OP_UNIQUE_ID    = 8'h4B;
  localparam logic [7:0] OP_PARAM_TABLE  = 8'h5A;

  localparam int OPCODE_BITS    = 8;
  localparam int UID_DUMMY_BITS = 32;
  localparam int PT_ADDR_BITS   = 24;
  localparam int PT_DUMMY_BITS  = 8;
  localparam int UID_BITS       = 128;

  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_OPCODE_LAST = CNT_W'(OPCODE_BITS - 1);
  localparam logic [CNT_W-1:0] CNT_ADDR_FIRST  = CNT_W'(OPCODE_BITS);
  localparam logic [CNT_W-1:0] CNT_ADDR_LAST   = CNT_W'(OPCODE_BITS + PT_ADDR_BITS - 1);
  localparam logic [CNT_W-1:0] CNT_UID_LAST    = CNT_W'(OPCODE_BITS + UID_DUMMY_BITS - 1);
  localparam logic [CNT_W-1:0] CNT_PT_LAST     = CNT_W'(OPCODE_BITS + PT_ADDR_BITS
                                                        + PT_DUMMY_BITS - 1);
  localparam logic [CNT_W-1:0] CNT_DATA        = CNT_W'(OPCODE_BITS + UID_DUMMY_BITS);

  localparam logic [23:0] PT_A_SIG0     = 24'h000000;
  localparam logic [23:0] PT_A_SIG1     = 24'h000001;
  localparam logic [23:0] PT_A_SIG2     = 24'h000002;
  localparam logic [23:0] PT_A_SIG3     = 24'h000003;
  localparam logic [23:0] PT_A_MINOR    = 24'h000004;
  localparam logic [23:0] PT_A_MAJOR    = 24'h000005;
  localparam logic [23:0] PT_A_NHDR     = 24'h000006;
  localparam logic [23:0] PT_A_H0_ID    = 24'h000008;
  localparam logic [23:0] PT_A_H0_MINOR = 24'h000009;
  localparam logic [23:0] PT_A_H0_MAJOR = 24'h00000A;
  localparam logic [23:0] PT_A_H0_LEN   = 24'h00000B;
  localparam logic [23:0] PT_A_H0_PTR0  = 24'h00000C;
  localparam logic [23:0] PT_A_H0_PTR1  = 24'h00000D;
  localparam logic [23:0] PT_A_H0_PTR2  = 24'h00000E;
  localparam logic [23:0] PT_A_H1_ID    = 24'h000010;
  localparam logic [23:0] PT_A_H1_MINOR = 24'h000011;
  localparam logic [23:0] PT_A_H1_MAJOR = 24'h000012;
  localparam logic [23:0] PT_A_H1_LEN   = 24'h000013;
  localparam logic [23:0] PT_A_H1_PTR0  = 24'h000014;
  localparam logic [23:0] PT_A_H1_PTR1  = 24'h000015;
  localparam logic [23:0] PT_A_H1_PTR2  = 24'h000016;

  localparam logic [31:0] PT_SIGNATURE = 32'h50444653;
  localparam logic [7:0]  PT_MINOR     = 8'h00;
  localparam logic [7:0]  PT_MAJOR     = 8'h01;
  localparam logic [7:0]  PT_NHDR      = 8'h01;
  localparam logic [7:0]  PT_UNUSED    = 8'hFF;
  localparam logic [7:0]  PT_H0_ID     = 8'h00;
  localparam logic [7:0]  PT_H0_LEN    = 8'h09;
  localparam logic [23:0] PT_H0_PTR    = 24'h000030;
  localparam logic [7:0]  PT_H1_LEN    = 8'h03;
  localparam logic [23:0] PT_H1_PTR    = 24'h000060;

  localparam int CLK_FREQ_KHZ    = 40000;
  localparam int RECOVERY_NS     = 30000;
  localparam int RECOVERY_CYCLES = (RECOVERY_NS * CLK_FREQ_KHZ + 999999) / 1000000;
  localparam int RECOVERY_W      = 11;
  localparam int PRIME_CYCLES    = 3;

  typedef struct packed {
    logic cs_n;
    logic si;
  } frc_link_in_t;

  typedef struct packed {
    logic so;
    logic so_oe_n;
  } frc_link_out_t;

  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_UID,
    MODE_TABLE,
    MODE_OTHER
  } frc_mode_t;

  typedef enum logic [1:0] {
    CTL_IDLE,
    CTL_ARMED,
    CTL_RECOVER
  } frc_ctl_t;

endpackage

/* File: verilog/frc_table_rom.sv */
// Parameter table read-only store with a registered read port.
`timescale 1ns/10ps
`default_nettype none
module frc_table_rom
  import frc_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5C // Arbitrary maker code.
)
(
  input  wire logic        clk_i,
  input  wire logic [23:0] addr_i,
  output var  logic [7:0]  data_o
);

  always_ff @(posedge clk_i)
  begin
    case (addr_i)
      PT_A_SIG0:     data_o <= PT_SIGNATURE[7:0];
      PT_A_SIG1:     data_o <= PT_SIGNATURE[15:8];
      PT_A_SIG2:     data_o <= PT_SIGNATURE[23:16];
      PT_A_SIG3:     data_o <= PT_SIGNATURE[31:24];
      PT_A_MINOR:    data_o <= PT_MINOR;
      PT_A_MAJOR:    data_o <= PT_MAJOR;
      PT_A_NHDR:     data_o <= PT_NHDR;
      PT_A_H0_ID:    data_o <= PT_H0_ID;
      PT_A_H0_MINOR: data_o <= PT_MINOR;
      PT_A_H0_MAJOR: data_o <= PT_MAJOR;
      PT_A_H0_LEN:   data_o <= PT_H0_LEN;
      PT_A_H0_PTR0:  data_o <= PT_H0_PTR[7:0];
      PT_A_H0_PTR1:  data_o <= PT_H0_PTR[15:8];
      PT_A_H0_PTR2:  data_o <= PT_H0_PTR[23:16];
      PT_A_H1_ID:    data_o <= MAKER_ID;
      PT_A_H1_MINOR: data_o <= PT_MINOR;
      PT_A_H1_MAJOR: data_o <= PT_MAJOR;
      PT_A_H1_LEN:   data_o <= PT_H1_LEN;
      PT_A_H1_PTR0:  data_o <= PT_H1_PTR[7:0];
      PT_A_H1_PTR1:  data_o <= PT_H1_PTR[15:8];
      PT_A_H1_PTR2:  data_o <= PT_H1_PTR[23:16];
      default:       data_o <= PT_UNUSED;
    endcase
  end

endmodule
`default_nettype wire

/* File: tb/frc_monitor.sv */
// Assertion checker for the flash command block.
`timescale 1ns/10ps
`default_nettype none
module frc_monitor
(
  input wire logic                   clk_i,
  input wire logic                   resetn_i,
  input wire frc_pkg::frc_link_in_t  link_i,
  input wire frc_pkg::frc_link_out_t link_o,
  input wire logic                   prog_busy_i,
  input wire logic                   soft_reset_o,
  input wire logic                   abort_prog_o,
  input wire logic                   reset_busy_o,
  input wire logic                   armed_o
);
  import frc_pkg::*;
  logic [RECOVERY_W-1:0] busy_cnt;
  // Counts the cycles of the recovery interval.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || !reset_busy_o)
      busy_cnt <= '0;
    else
      busy_cnt <= busy_cnt + 1'b1;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_rst_pulse;
    soft_reset_o ##1 !soft_reset_o;
  endsequence
  sequence s_recover;
    reset_busy_o && !armed_o;
  endsequence
  AST_RST_ONE: assert property (soft_reset_o |-> s_rst_pulse)
    else $error("reset pulse too long");
  AST_RST_BUSY: assert property (soft_reset_o |=> s_recover)
    else $error("no recovery after reset");
  AST_RST_ARMED: assert property (soft_reset_o |-> $past(armed_o))
    else $error("reset without arm");
  AST_RST_IDLE: assert property (soft_reset_o |-> !$past(reset_busy_o))
    else $error("reset taken during recovery");
  AST_ABORT: assert property (abort_prog_o |-> soft_reset_o && $past(prog_busy_i))
    else $error("abort without reset or busy");
  AST_ARM_CS: assert property ($rose(armed_o) |-> link_i.cs_n)
    else $error("arm taken while chip select low");
  AST_BUSY_LEN: assert property ($fell(reset_busy_o) |->
    busy_cnt == RECOVERY_W'(RECOVERY_CYCLES))
    else $error("recovery length wrong");
  AST_CS_QUIET: assert property (link_i.cs_n |-> link_o.so_oe_n && !link_o.so)
    else $error("output driven while deselected");
endmodule
bind frc_top frc_monitor i_frc_monitor (.clk_i, .resetn_i, .link_i, .link_o, .prog_busy_i,
  .soft_reset_o, .abort_prog_o, .reset_busy_o, .armed_o);
`default_nettype wire

/* File: tb/frc_host_model.sv */
// Host serial controller model that clocks frames onto the link.
`timescale 1ns/10ps
`default_nettype none
module frc_host_model
(
  output var  logic                   sclk_o,
  output var  frc_pkg::frc_link_in_t  link_o,
  input  wire frc_pkg::frc_link_out_t link_i,
  output var  logic [7:0]             rx_o,
  output var  logic                   rx_v_o
);
  import frc_pkg::*;
  initial
  begin
    sclk_o = 1'b0;
    link_o = 2'b00;
    rx_o = 8'h00;
    rx_v_o = 1'b0;
    // Chip select rises once at power-up so the link logic sees a clearing edge.
    #5 link_o.cs_n = 1'b1;
  end
  // Sends nb bits MSB first, then reads nr bits; the clock stands still between frames.
  task automatic frame(input logic [39:0] tx, input int nb, input int nr);
    link_o.cs_n = 1'b0;
    for (int i = 0; i < nb + nr; i++)
    begin
      link_o.si = (i < nb) ? tx[nb-1-i] : ~link_o.si;
      #7.5 sclk_o = 1'b1;
      rx_o = {rx_o[6:0], link_i.so};
      rx_v_o = (i >= nb) && ((i - nb) % 8 == 7);
      #7.5 sclk_o = 1'b0;
      rx_v_o = 1'b0;
    end
    #7.5 link_o.cs_n = 1'b1;
    link_o.si = ~link_o.si;
    #200;
  endtask
endmodule
`default_nettype wire

/* File: tb/frc_top_tb.sv */
// Self-checking bench for the flash command block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch at %0t: got %h want %h", $time, (a), (e)); end end
module frc_top_tb;
  import frc_pkg::*;
  localparam logic [7:0] MAKER = 8'hA7; // Arbitrary maker code.
  localparam logic [7:0] TBL [25] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01,
    8'hFF, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF, MAKER, 8'h00, 8'h01,
    8'h03, 8'h60, 8'h00, 8'h00, 8'hFF, 8'hFF};
  logic          clk_i;
  logic          resetn_i;
  logic          sclk_i;
  logic          prog_busy_i;
  logic          soft_reset_o;
  logic          abort_prog_o;
  logic          reset_busy_o;
  logic          armed_o;
  logic          rx_v;
  logic [7:0]    rx_b;
  logic [7:0]    exp_b;
  logic          exp_a;
  logic [127:0]  unique_id_i;
  frc_link_in_t  link_i;
  frc_link_out_t link_o;
  int            miscompares = 0;
  int            n_tests = 0;
  int            cycles = 0;
  logic [7:0]    exp_rd[$];
  logic          exp_rst[$];
  frc_top #(.MAKER_ID(MAKER)) i_frc_top (.clk_i, .resetn_i, .sclk_i, .link_i, .link_o,
    .unique_id_i, .prog_busy_i, .soft_reset_o, .abort_prog_o, .reset_busy_o, .armed_o);
  frc_host_model i_frc_host_model (.sclk_o(sclk_i), .link_o(link_i), .link_i(link_o),
    .rx_o(rx_b), .rx_v_o(rx_v));
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic end_sim;
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      miscompares++;
      end_sim();
    end
  end
  always @(posedge rx_v)
  begin
    exp_b = exp_rd.size() ? exp_rd.pop_front() : 8'hXX;
    `CHK(rx_b, exp_b)
  end
  always @(negedge clk_i)
    if (soft_reset_o === 1'b1)
    begin
      exp_a = exp_rst.size() ? exp_rst.pop_front() : 1'bx;
      `CHK(abort_prog_o, exp_a)
    end
  initial
  begin
    int a;
    int n;
    void'($urandom(32'h72AE3CCB));
    resetn_i = 1'b0;
    prog_busy_i = 1'b0;
    unique_id_i = {$urandom, $urandom, $urandom, $urandom};
    repeat (12) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (8) @(negedge clk_i);
    for (int k = 0; k < 4; k++)
    begin
      a = (k == 0) ? 0 : $urandom_range(23);
      n = (k == 0) ? 25 : $urandom_range(4, 1);
      for (int j = 0; j < n; j++)
        exp_rd.push_back(TBL[(a + j > 24) ? 24 : a + j]);
      i_frc_host_model.frame({16'h5A00, 8'h00, a[7:0], 8'h00}, 40, 8 * n + k);
      `CHK(link_o, 2'b01)
    end
    for (int k = 15; k >= 0; k--)
      exp_rd.push_back(unique_id_i[8*k +: 8]);
    exp_rd.push_back(unique_id_i[127:120]);
    i_frc_host_model.frame({8'h4B, 32'h0}, 40, 136);
    exp_rd.push_back(8'h00);
    i_frc_host_model.frame({8'h4C, 32'h0}, 40, 8);
    for (int k = 0; k < 2; k++)
    begin
      @(negedge clk_i);
      prog_busy_i = k[0];
      exp_rst.push_back(k[0]);
      i_frc_host_model.frame(40'h66, 8, 0);
      `CHK(armed_o, 1'b1)
      i_frc_host_model.frame(40'h99, 8, 0);
      i_frc_host_model.frame(40'h66, 8, 0);
      `CHK(armed_o, 1'b0)
      for (n = 0; n < 1300 && reset_busy_o !== 1'b0; n++)
        @(negedge clk_i);
      `CHK(reset_busy_o, 1'b0)
    end
    for (int k = 0; k < 3; k++)
    begin
      i_frc_host_model.frame(40'h66, 8, 0);
      i_frc_host_model.frame(k == 0 ? 40'h00 : k == 1 ? 40'h4B : 40'h132, 8 + k / 2, 0);
      `CHK(armed_o, 1'b0)
      i_frc_host_model.frame(40'h99, 8, 0);
    end
    repeat (20) @(negedge clk_i);
    `CHK(exp_rd.size() + exp_rst.size(), 0)
    end_sim();
  end
endmodule
`default_nettype wire
